// file: esc_pkg.sv
// Shared types and constants for the erase-suspend flash command controller.
// Assumes a x16 parallel flash with 22 word-address bits and a 100 MHz host clock.
package esc_pkg;

  localparam int          ADDR_W        = 22;
  localparam int          DATA_W        = 16;
  localparam int          SECT_LSB      = 15;

  // Command addresses and data codes
  localparam logic [21:0] A_UNLOCK1     = 22'h000555;
  localparam logic [21:0] A_UNLOCK2     = 22'h0002AA;
  localparam logic [15:0] D_UNLOCK1     = 16'h00AA;
  localparam logic [15:0] D_UNLOCK2     = 16'h0055;
  localparam logic [15:0] D_WORD_PROG   = 16'h00A0;
  localparam logic [15:0] D_BUF_LOAD    = 16'h0025;
  localparam logic [15:0] D_BUF_CONFIRM = 16'h0029;
  localparam logic [15:0] D_RESUME      = 16'h0030;
  localparam logic [15:0] D_PROG_RESUME = 16'h0050;
  localparam logic [15:0] D_PROG_SUSP   = 16'h0051;
  localparam logic [15:0] D_PROG_SUSP_L = 16'h00B0;
  localparam logic [15:0] D_RESET       = 16'h00F0;
  localparam logic [15:0] D_STAT_READ   = 16'h0070;
  localparam logic [15:0] D_STAT_CLEAR  = 16'h0071;

  // Status word bits
  localparam int          ST_READY_BIT  = 7;
  localparam int          ST_FAIL_BIT   = 5;

  // Bus timing, least times rounded up to whole cycles
  localparam int          CLK_NS        = 10;
  localparam int          T_WP_NS       = 35;
  localparam int          T_ACC_NS      = 70;
  localparam int          T_REC_NS      = 20;
  localparam int          T_PSL_NS      = 20000;
  localparam int          SYNC_CYC      = 2;
  localparam logic [3:0]  WP_CYC        = 4'((T_WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0]  ACC_CYC       = 4'((T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC);
  localparam logic [3:0]  REC_CYC       = 4'((T_REC_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] PSL_CYC       = 12'((T_PSL_NS + CLK_NS - 1) / CLK_NS);

  typedef enum logic [2:0] {
    OP_RESUME_ERASE = 3'b000,
    OP_WORD_PROG    = 3'b001,
    OP_BUF_PROG     = 3'b010,
    OP_PROG_SUSPEND = 3'b011,
    OP_PROG_RESUME  = 3'b100,
    OP_RESET        = 3'b101,
    OP_STAT_READ    = 3'b110,
    OP_STAT_CLEAR   = 3'b111
  } esc_op_t;

  // Host view of the device state
  typedef enum logic [2:0] {
    MODE_ERASE_SUSP = 3'b000,
    MODE_PROG_BUSY  = 3'b001,
    MODE_PROG_SUSP  = 3'b010,
    MODE_HANG       = 3'b011,
    MODE_ERASING    = 3'b100
  } esc_mode_t;

  typedef struct packed {
    esc_op_t     op;
    logic        legacy;
    logic [21:0] addr;
    logic [6:0]  count;
  } esc_cmd_t;

  typedef struct packed {
    logic        write;
    logic [21:0] addr;
    logic [15:0] data;
  } esc_cyc_t;

  typedef struct packed {
    logic [21:0] addr;
    logic [15:0] dq;
    logic        dq_oe;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
  } esc_pins_t;

endpackage : esc_pkg

// file: esc_bus_cycle.sv
// One asynchronous flash bus cycle (write or read) driven from registers.
// Assumes start_in only while idle; dq_in comes from the pins, another domain.
`timescale 1ns/1ps
module esc_bus_cycle (
  input  wire logic              clock_in,
  input  wire logic              rst_in,
  input  wire logic              start_in,
  input  wire esc_pkg::esc_cyc_t cyc_in,
  input  wire logic [15:0]       dq_in,
  output esc_pkg::esc_pins_t     pins_out,
  output logic [15:0]            rdata_out,
  output logic                   done_out
);

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_ACT  = 2'b01,
    PH_REC  = 2'b10
  } esc_phase_t;

  esc_phase_t         phase_ff, nxt_phase;
  logic [3:0]         cnt_ff, nxt_cnt;
  esc_pkg::esc_pins_t pins_ff, nxt_pins;
  logic [15:0]        rdata_ff, nxt_rdata;
  logic               done_ff, nxt_done;
  logic [15:0]        dq_meta_ff, dq_sync_ff;

  always_comb
  begin
    nxt_phase = phase_ff;
    nxt_cnt   = cnt_ff;
    nxt_pins  = pins_ff;
    nxt_rdata = rdata_ff;
    nxt_done  = 1'b0;
    case (phase_ff)
      PH_IDLE:
      begin
        if (start_in)
        begin
          nxt_phase      = PH_ACT;
          nxt_pins.addr  = cyc_in.addr;
          nxt_pins.dq    = cyc_in.data;
          nxt_pins.dq_oe = cyc_in.write;
          nxt_pins.ce_n  = 1'b0;
          nxt_pins.we_n  = ~cyc_in.write;
          nxt_pins.oe_n  = cyc_in.write;
          nxt_cnt        = cyc_in.write ? esc_pkg::WP_CYC : esc_pkg::ACC_CYC;
        end
      end
      PH_ACT:
      begin
        if (cnt_ff == 4'h1)
        begin
          nxt_phase     = PH_REC;
          nxt_cnt       = esc_pkg::REC_CYC;
          nxt_pins.ce_n = 1'b1;
          nxt_pins.we_n = 1'b1;
          nxt_pins.oe_n = 1'b1;
          if (!pins_ff.dq_oe)
            nxt_rdata = dq_sync_ff;
        end
        else
          nxt_cnt = cnt_ff - 4'h1;
      end
      PH_REC:
      begin
        if (cnt_ff == 4'h1)
        begin
          nxt_phase      = PH_IDLE;
          nxt_pins.dq_oe = 1'b0;
          nxt_done       = 1'b1;
        end
        else
          nxt_cnt = cnt_ff - 4'h1;
      end
      default:
        nxt_phase = PH_IDLE;
    endcase
  end

  always_ff @(posedge clock_in)
  begin
    dq_meta_ff <= dq_in;
    dq_sync_ff <= dq_meta_ff;
    if (rst_in)
    begin
      phase_ff <= PH_IDLE;
      cnt_ff   <= 4'h0;
      pins_ff  <= '{addr: 22'h000000, dq: 16'h0000, dq_oe: 1'b0,
                    ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
      rdata_ff <= 16'h0000;
      done_ff  <= 1'b0;
    end
    else
    begin
      phase_ff <= nxt_phase;
      cnt_ff   <= nxt_cnt;
      pins_ff  <= nxt_pins;
      rdata_ff <= nxt_rdata;
      done_ff  <= nxt_done;
    end
  end

  assign pins_out  = pins_ff;
  assign rdata_out = rdata_ff;
  assign done_out  = done_ff;

endmodule : esc_bus_cycle

// file: esc_ctrl.sv
// Host controller that drives a flash held in erase suspend through its bus pins.
// Assumes the flash is erase-suspended when rst_in is released.
`timescale 1ns/1ps
module esc_ctrl (
  input  wire logic              clock_in,
  input  wire logic              rst_in,
  input  wire logic              cmd_valid_in,
  input  wire esc_pkg::esc_cmd_t cmd_in,
  input  wire logic              data_valid_in,
  input  wire logic [15:0]       data_in,
  input  wire logic [15:0]       dq_in,
  output esc_pkg::esc_pins_t     pins_out,
  output logic                   cmd_ready_out,
  output logic                   data_ready_out,
  output logic                   done_out,
  output logic                   refused_out,
  output logic [15:0]            status_out,
  output esc_pkg::esc_mode_t     mode_out
);

  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0000,
    ST_UL1     = 4'b0001,
    ST_UL2     = 4'b0010,
    ST_ENTRY   = 4'b0011,
    ST_WCOUNT  = 4'b0100,
    ST_WDATA   = 4'b0101,
    ST_CONFIRM = 4'b0110,
    ST_SINGLE  = 4'b0111,
    ST_READ    = 4'b1000,
    ST_LATENCY = 4'b1001
  } esc_state_t;

  esc_state_t         state_ff, nxt_state;
  esc_pkg::esc_mode_t mode_ff, nxt_mode;
  esc_pkg::esc_cmd_t  cmd_ff, nxt_cmd;
  esc_pkg::esc_cyc_t  cyc_ff, nxt_cyc;
  logic               start_ff, nxt_start;
  logic               pend_ff, nxt_pend;
  logic [7:0]         remain_ff, nxt_remain;
  logic [21:0]        waddr_ff, nxt_waddr;
  logic [11:0]        wait_ff, nxt_wait;
  logic               cmd_ready_ff, nxt_cmd_ready;
  logic               data_ready_ff, nxt_data_ready;
  logic               done_ff, nxt_done;
  logic               refused_ff, nxt_refused;
  logic [15:0]        status_ff, nxt_status;
  logic               eng_done;
  logic [15:0]        eng_rdata;

  // Sector address: upper bits of the command address, offset cleared
  function automatic logic [21:0] sect(input logic [21:0] a);
    sect = {a[21:esc_pkg::SECT_LSB], 15'h0000};
  endfunction : sect

  function automatic esc_pkg::esc_cyc_t wr(input logic [21:0] a, input logic [15:0] d);
    wr = '{write: 1'b1, addr: a, data: d};
  endfunction : wr

  // Which operations the device accepts in each host mode
  function automatic logic legal(input esc_pkg::esc_mode_t m, input esc_pkg::esc_op_t o);
    case (m)
      esc_pkg::MODE_ERASE_SUSP: legal = (o != esc_pkg::OP_PROG_SUSPEND) &&
                                        (o != esc_pkg::OP_PROG_RESUME);
      esc_pkg::MODE_PROG_BUSY:  legal = (o == esc_pkg::OP_PROG_SUSPEND) ||
                                        (o == esc_pkg::OP_STAT_READ);
      esc_pkg::MODE_HANG:       legal = (o == esc_pkg::OP_RESET) ||
                                        (o == esc_pkg::OP_STAT_READ);
      esc_pkg::MODE_PROG_SUSP:  legal = (o == esc_pkg::OP_PROG_RESUME) ||
                                        (o == esc_pkg::OP_RESET) ||
                                        (o == esc_pkg::OP_STAT_READ);
      default:                  legal = (o == esc_pkg::OP_STAT_READ);
    endcase
  endfunction : legal

  // Single-write command for each operation sent through ST_SINGLE
  function automatic esc_pkg::esc_cyc_t single(input esc_pkg::esc_cmd_t c);
    case (c.op)
      esc_pkg::OP_RESUME_ERASE: single = wr(c.addr, esc_pkg::D_RESUME);
      esc_pkg::OP_PROG_SUSPEND: single = wr(c.addr, c.legacy ? esc_pkg::D_PROG_SUSP_L
                                                             : esc_pkg::D_PROG_SUSP);
      esc_pkg::OP_PROG_RESUME:  single = wr(c.addr, c.legacy ? esc_pkg::D_RESUME
                                                             : esc_pkg::D_PROG_RESUME);
      esc_pkg::OP_RESET:        single = wr(c.addr, esc_pkg::D_RESET);
      esc_pkg::OP_STAT_CLEAR:   single = wr(esc_pkg::A_UNLOCK1, esc_pkg::D_STAT_CLEAR);
      default:                  single = wr(esc_pkg::A_UNLOCK1, esc_pkg::D_STAT_READ);
    endcase
  endfunction : single

  always_comb
  begin
    nxt_state      = state_ff;
    nxt_mode       = mode_ff;
    nxt_cmd        = cmd_ff;
    nxt_cyc        = cyc_ff;
    nxt_start      = 1'b0;
    nxt_pend       = pend_ff;
    nxt_remain     = remain_ff;
    nxt_waddr      = waddr_ff;
    nxt_wait       = wait_ff;
    nxt_cmd_ready  = cmd_ready_ff;
    nxt_data_ready = data_ready_ff;
    nxt_done       = 1'b0;
    nxt_refused    = 1'b0;
    nxt_status     = status_ff;
    case (state_ff)
      ST_IDLE:
      begin
        if (cmd_valid_in && cmd_ready_ff)
        begin
          if (!legal(mode_ff, cmd_in.op))
            nxt_refused = 1'b1;
          else
          begin
            nxt_cmd       = cmd_in;
            nxt_cmd_ready = 1'b0;
            nxt_waddr     = cmd_in.addr;
            nxt_remain    = {1'b0, cmd_in.count};
            if (cmd_in.op == esc_pkg::OP_WORD_PROG || cmd_in.op == esc_pkg::OP_BUF_PROG)
              nxt_state = ST_UL1;
            else
              nxt_state = ST_SINGLE;
          end
        end
      end
      ST_UL1, ST_UL2, ST_ENTRY, ST_WCOUNT, ST_CONFIRM, ST_SINGLE, ST_READ:
      begin
        if (!pend_ff)
        begin
          nxt_pend  = 1'b1;
          nxt_start = 1'b1;
          case (state_ff)
            ST_UL1:    nxt_cyc = wr(esc_pkg::A_UNLOCK1, esc_pkg::D_UNLOCK1);
            ST_UL2:    nxt_cyc = wr(esc_pkg::A_UNLOCK2, esc_pkg::D_UNLOCK2);
            ST_ENTRY:  nxt_cyc = (cmd_ff.op == esc_pkg::OP_WORD_PROG)
                               ? wr(esc_pkg::A_UNLOCK1, esc_pkg::D_WORD_PROG)
                               : wr(sect(cmd_ff.addr), esc_pkg::D_BUF_LOAD);
            ST_WCOUNT: nxt_cyc = wr(sect(cmd_ff.addr), {9'h000, cmd_ff.count});
            ST_CONFIRM: nxt_cyc = wr(sect(cmd_ff.addr), esc_pkg::D_BUF_CONFIRM);
            ST_SINGLE: nxt_cyc = single(cmd_ff);
            default:   nxt_cyc = '{write: 1'b0, addr: 22'h000000, data: 16'h0000};
          endcase
        end
        else if (eng_done)
        begin
          nxt_pend = 1'b0;
          case (state_ff)
            ST_UL1: nxt_state = ST_UL2;
            ST_UL2: nxt_state = ST_ENTRY;
            ST_ENTRY:
            begin
              nxt_state      = (cmd_ff.op == esc_pkg::OP_WORD_PROG) ? ST_WDATA : ST_WCOUNT;
              nxt_data_ready = (cmd_ff.op == esc_pkg::OP_WORD_PROG);
            end
            ST_WCOUNT:
            begin
              nxt_state      = ST_WDATA;
              nxt_data_ready = 1'b1;
            end
            ST_CONFIRM:
            begin
              nxt_mode      = esc_pkg::MODE_PROG_BUSY;
              nxt_state     = ST_IDLE;
              nxt_cmd_ready = 1'b1;
              nxt_done      = 1'b1;
            end
            ST_SINGLE:
            begin
              nxt_state     = ST_IDLE;
              nxt_cmd_ready = 1'b1;
              nxt_done      = 1'b1;
              case (cmd_ff.op)
                esc_pkg::OP_RESUME_ERASE: nxt_mode = esc_pkg::MODE_ERASING;
                esc_pkg::OP_PROG_RESUME:  nxt_mode = esc_pkg::MODE_PROG_BUSY;
                esc_pkg::OP_PROG_SUSPEND:
                begin
                  nxt_state     = ST_LATENCY;
                  nxt_wait      = esc_pkg::PSL_CYC;
                  nxt_cmd_ready = 1'b0;
                  nxt_done      = 1'b0;
                end
                esc_pkg::OP_RESET:
                  if (mode_ff == esc_pkg::MODE_HANG)
                    nxt_mode = esc_pkg::MODE_ERASE_SUSP;
                esc_pkg::OP_STAT_READ:
                begin
                  nxt_state     = ST_READ;
                  nxt_cmd_ready = 1'b0;
                  nxt_done      = 1'b0;
                end
                default: nxt_mode = mode_ff;
              endcase
            end
            default:
            begin
              nxt_status    = eng_rdata;
              nxt_state     = ST_IDLE;
              nxt_cmd_ready = 1'b1;
              nxt_done      = 1'b1;
              if (mode_ff == esc_pkg::MODE_PROG_BUSY && eng_rdata[esc_pkg::ST_READY_BIT])
                nxt_mode = eng_rdata[esc_pkg::ST_FAIL_BIT] ? esc_pkg::MODE_HANG
                                                           : esc_pkg::MODE_ERASE_SUSP;
            end
          endcase
        end
      end
      ST_WDATA:
      begin
        if (data_valid_in && data_ready_ff)
        begin
          nxt_data_ready = 1'b0;
          nxt_pend       = 1'b1;
          nxt_start      = 1'b1;
          nxt_cyc        = wr(nxt_cmd.op == esc_pkg::OP_WORD_PROG ? cmd_ff.addr : waddr_ff,
                              data_in);
        end
        else if (pend_ff && eng_done)
        begin
          nxt_pend   = 1'b0;
          nxt_remain = remain_ff - 8'h01;
          nxt_waddr  = waddr_ff + 22'h000001;
          if (cmd_ff.op == esc_pkg::OP_WORD_PROG)
          begin
            nxt_mode      = esc_pkg::MODE_PROG_BUSY;
            nxt_state     = ST_IDLE;
            nxt_cmd_ready = 1'b1;
            nxt_done      = 1'b1;
          end
          else if (remain_ff == 8'h00)
            nxt_state = ST_CONFIRM;
          else
            nxt_data_ready = 1'b1;
        end
      end
      ST_LATENCY:
      begin
        if (wait_ff == 12'h001)
        begin
          nxt_mode      = esc_pkg::MODE_PROG_SUSP;
          nxt_state     = ST_IDLE;
          nxt_cmd_ready = 1'b1;
          nxt_done      = 1'b1;
        end
        else
          nxt_wait = wait_ff - 12'h001;
      end
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      state_ff      <= ST_IDLE;
      mode_ff       <= esc_pkg::MODE_ERASE_SUSP;
      cmd_ff        <= '{op: esc_pkg::OP_STAT_READ, legacy: 1'b0,
                         addr: 22'h000000, count: 7'h00};
      cyc_ff        <= '{write: 1'b0, addr: 22'h000000, data: 16'h0000};
      start_ff      <= 1'b0;
      pend_ff       <= 1'b0;
      remain_ff     <= 8'h00;
      waddr_ff      <= 22'h000000;
      wait_ff       <= 12'h000;
      cmd_ready_ff  <= 1'b1;
      data_ready_ff <= 1'b0;
      done_ff       <= 1'b0;
      refused_ff    <= 1'b0;
      status_ff     <= 16'h0000;
    end
    else
    begin
      state_ff      <= nxt_state;
      mode_ff       <= nxt_mode;
      cmd_ff        <= nxt_cmd;
      cyc_ff        <= nxt_cyc;
      start_ff      <= nxt_start;
      pend_ff       <= nxt_pend;
      remain_ff     <= nxt_remain;
      waddr_ff      <= nxt_waddr;
      wait_ff       <= nxt_wait;
      cmd_ready_ff  <= nxt_cmd_ready;
      data_ready_ff <= nxt_data_ready;
      done_ff       <= nxt_done;
      refused_ff    <= nxt_refused;
      status_ff     <= nxt_status;
    end
  end

  esc_bus_cycle u_bus (
    .clock_in (clock_in),
    .rst_in   (rst_in),
    .start_in (start_ff),
    .cyc_in   (cyc_ff),
    .dq_in    (dq_in),
    .pins_out (pins_out),
    .rdata_out(eng_rdata),
    .done_out (eng_done)
  );

  assign cmd_ready_out  = cmd_ready_ff;
  assign data_ready_out = data_ready_ff;
  assign done_out       = done_ff;
  assign refused_out    = refused_ff;
  assign status_out     = status_ff;
  assign mode_out       = mode_ff;

endmodule : esc_ctrl

// file: esc_monitor.sv
// Concurrent checks on the ports of the erase-suspend flash controller.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module esc_monitor (
  input wire logic               clock_in,
  input wire logic               rst_in,
  input wire logic               cmd_valid_in,
  input wire esc_pkg::esc_cmd_t  cmd_in,
  input wire logic               data_valid_in,
  input wire logic [15:0]        data_in,
  input wire logic [15:0]        dq_in,
  input wire esc_pkg::esc_pins_t pins_out,
  input wire logic               cmd_ready_out,
  input wire logic               data_ready_out,
  input wire logic               done_out,
  input wire logic               refused_out,
  input wire logic [15:0]        status_out,
  input wire esc_pkg::esc_mode_t mode_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  logic              take;
  esc_pkg::esc_op_t  op;
  assign take = cmd_valid_in && cmd_ready_out;
  assign op   = cmd_in.op;

  a_reset_idle: assert property (disable iff (1'b0) rst_in |=> pins_out.ce_n
    && pins_out.we_n && !pins_out.dq_oe && cmd_ready_out && mode_out == esc_pkg::MODE_ERASE_SUSP)
    else $error("outputs not idle after reset");
  a_taken_ready: assert property (take |=> cmd_ready_out == refused_out)
    else $error("ready level wrong after a taken command");
  a_we_width: assert property ($fell(pins_out.we_n) |->
    (!pins_out.we_n && !pins_out.ce_n && pins_out.dq_oe)[*4] ##1 pins_out.we_n)
    else $error("write strobe not four cycles");
  a_write_stable: assert property (!pins_out.we_n |=>
    $stable(pins_out.addr) && $stable(pins_out.dq))
    else $error("address or data moved under write strobe");
  a_refuse_idle: assert property (take && mode_out == esc_pkg::MODE_ERASE_SUSP &&
    (op == esc_pkg::OP_PROG_SUSPEND || op == esc_pkg::OP_PROG_RESUME) |=> refused_out)
    else $error("suspend or resume not refused in erase suspend");
  a_busy_refuse: assert property (take && mode_out == esc_pkg::MODE_PROG_BUSY &&
    op != esc_pkg::OP_PROG_SUSPEND && op != esc_pkg::OP_STAT_READ |=> refused_out)
    else $error("command not refused while programming");
  a_resume_erase: assert property (take && op == esc_pkg::OP_RESUME_ERASE &&
    mode_out == esc_pkg::MODE_ERASE_SUSP |-> ##[1:40]
    (done_out && mode_out == esc_pkg::MODE_ERASING))
    else $error("erase resume did not reach erasing");
  a_hang_reset: assert property (take && op == esc_pkg::OP_RESET &&
    mode_out == esc_pkg::MODE_HANG |-> ##[1:40]
    (done_out && mode_out == esc_pkg::MODE_ERASE_SUSP))
    else $error("reset after hang did not return to erase suspend");
  a_prog_resume: assert property (take && op == esc_pkg::OP_PROG_RESUME &&
    mode_out == esc_pkg::MODE_PROG_SUSP |-> ##[1:40]
    (done_out && mode_out == esc_pkg::MODE_PROG_BUSY))
    else $error("program resume did not restart programming");
  a_psusp_keep: assert property (take && mode_out == esc_pkg::MODE_PROG_SUSP &&
    (op == esc_pkg::OP_RESET || op == esc_pkg::OP_STAT_READ) |-> ##[1:40]
    (done_out && mode_out == esc_pkg::MODE_PROG_SUSP))
    else $error("program suspend left on reset or status read");
endmodule : esc_monitor

bind esc_ctrl esc_monitor i_esc_monitor (
  .clock_in(clock_in), .rst_in(rst_in), .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in),
  .data_valid_in(data_valid_in), .data_in(data_in), .dq_in(dq_in), .pins_out(pins_out),
  .cmd_ready_out(cmd_ready_out), .data_ready_out(data_ready_out), .done_out(done_out),
  .refused_out(refused_out), .status_out(status_out), .mode_out(mode_out)
);

// file: esc_flash_model.sv
// Behavioural flash held in erase suspend, decoding write cycles on its pins.
// Assumes the controller's registered pins and the bench clock.
`timescale 1ns/1ps
module esc_flash_model (
  input  wire logic               clock_in,
  input  wire logic               rst_in,
  input  wire logic               hang_in,
  input  wire esc_pkg::esc_pins_t pins_in,
  output logic [15:0]             dq_out,
  output logic                    err_out,
  output logic [3:0]              st_out
);
  localparam logic [3:0] S_SUSP = 4'h0, S_UL1 = 4'h1, S_UL2 = 4'h2, S_WP = 4'h3;
  localparam logic [3:0] S_BL = 4'h4, S_BD = 4'h5, S_PG = 4'h6, S_PSR = 4'h7;
  localparam logic [3:0] S_PS = 4'h8, S_ERS = 4'h9, S_ERR = 4'hA;
  logic [21:0] a;
  logic [7:0]  d;
  logic [6:0]  sa;
  logic        we_q, lo, rd, rdy, fail;
  logic [15:0] held;
  int          wc, tmr, lat;
  assign a    = pins_in.addr;
  assign d    = pins_in.dq[7:0];
  assign lo   = a[11:0] == 12'h555;
  assign rd   = !pins_in.ce_n && !pins_in.oe_n;
  assign rdy  = !(st_out == S_PG || st_out == S_PSR) || (hang_in && tmr == 0);
  assign fail = (st_out == S_PG && hang_in && tmr == 0) || st_out == S_ERR;
  // Released bus shows the inverse of the last word
  assign dq_out = rd ? {8'h00, rdy, 1'b0, fail, 5'h00} : ~held;

  always @(posedge clock_in) begin
    we_q <= pins_in.we_n;
    if (rd)
      held <= dq_out;
    if (rst_in) begin
      st_out <= S_SUSP;
      err_out <= 1'b0;
      tmr <= 0;
      held <= 16'h0000;
    end
    else begin
      if (st_out == S_PG && tmr > 0)
        tmr <= tmr - 1;
      if (st_out == S_PG && tmr == 0 && !hang_in)
        st_out <= S_SUSP;
      if (st_out == S_PSR)
        lat <= lat - 1;
      if (st_out == S_PSR && lat == 0)
        st_out <= S_PS;
      if (!we_q && pins_in.we_n) begin
        case (st_out)
          S_SUSP: if (d == 8'hAA && lo) st_out <= S_UL1;
            else if (d == 8'h30) st_out <= S_ERS;
          S_UL1: if (d == 8'h55 && a[11:0] == 12'h2AA) st_out <= S_UL2;
            else err_out <= 1'b1;
          S_UL2: if (d == 8'hA0 && lo) st_out <= S_WP;
            else if (d == 8'h25) {st_out, sa} <= {S_BL, a[21:15]};
            else err_out <= 1'b1;
          S_WP: {st_out, tmr} <= {S_PG, 32'd300};
          S_BL: if (a[21:15] != sa || pins_in.dq > 16'h007F) {st_out, err_out} <= {S_ERR, 1'b1};
            else {st_out, wc} <= {S_BD, 16'h0000, pins_in.dq};
          S_BD: if (a[21:15] != sa) {st_out, err_out} <= {S_ERR, 1'b1};
            else if (wc >= 0) wc <= wc - 1;
            else if (d == 8'h29) {st_out, tmr} <= {S_PG, 32'd300};
            else {st_out, err_out} <= {S_ERR, 1'b1};
          S_PG: if (d == 8'h51 || d == 8'hB0) {st_out, lat} <= {S_PSR, 32'd100};
            else if (d == 8'hF0 && hang_in && tmr == 0) st_out <= S_SUSP;
          S_PS: if (d == 8'h30 || d == 8'h50) st_out <= S_PG;
          default: ;
        endcase
      end
    end
  end
endmodule : esc_flash_model

// file: tb_erase_suspend_command_fsm.sv
// Self-checking bench: controller against the behavioural flash model.
// Assumes the controller starts with the flash erase-suspended.
`timescale 1ns/1ps
module tb_erase_suspend_command_fsm;
  typedef struct {
    esc_pkg::esc_op_t   op;
    esc_pkg::esc_mode_t m;
    int                 leg, n, w, rf;
  } esc_row_t;
  logic               clock_in, rst_in, cmd_valid_in, data_valid_in, hang, err;
  logic               cmd_ready_out, data_ready_out, done_out, refused_out;
  logic [15:0]        data_in, dq_in, status_out;
  logic [3:0]         st;
  esc_pkg::esc_cmd_t  cmd_in;
  esc_pkg::esc_pins_t pins_out;
  esc_pkg::esc_mode_t mode_out;
  int                 n_fail, tests_run;
  esc_row_t           rows [19];

  esc_ctrl i_esc_ctrl (.clock_in(clock_in), .rst_in(rst_in), .cmd_valid_in(cmd_valid_in),
    .cmd_in(cmd_in), .data_valid_in(data_valid_in), .data_in(data_in), .dq_in(dq_in),
    .pins_out(pins_out), .cmd_ready_out(cmd_ready_out), .data_ready_out(data_ready_out),
    .done_out(done_out), .refused_out(refused_out), .status_out(status_out),
    .mode_out(mode_out));
  esc_flash_model i_esc_flash_model (.clock_in(clock_in), .rst_in(rst_in), .hang_in(hang),
    .pins_in(pins_out), .dq_out(dq_in), .err_out(err), .st_out(st));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict

  task automatic send(input esc_row_t r);
    int k;
    repeat (r.w + 1) @(negedge clock_in);
    while (cmd_ready_out !== 1'b1)
      @(negedge clock_in);
    cmd_in = '{r.op, 1'(r.leg), 22'h2A8004, 7'(r.n)};
    cmd_valid_in = 1'b1;
    @(negedge clock_in);
    cmd_valid_in = 1'b0;
    for (k = 0; k < 3000 && done_out !== 1'b1 && refused_out !== 1'b1; k++)
      @(negedge clock_in);
    chk({14'h0, done_out, refused_out}, {14'h0, r.rf == 0, r.rf == 1});
    chk({13'h0, mode_out}, {13'h0, r.m});
  endtask : send

  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  // New data word only while the controller is not offering to take one
  always @(negedge clock_in)
    if (!data_ready_out)
      data_in <= data_in + 16'h1111;

  initial begin
    repeat (30000) @(posedge clock_in);
    n_fail++;
    give_verdict();
  end

  initial begin
    rows = '{
      '{esc_pkg::OP_STAT_READ, esc_pkg::MODE_ERASE_SUSP, 0, 0, 0, 0},
      '{esc_pkg::OP_STAT_CLEAR, esc_pkg::MODE_ERASE_SUSP, 0, 0, 0, 0},
      '{esc_pkg::OP_RESET, esc_pkg::MODE_ERASE_SUSP, 0, 0, 0, 0},
      '{esc_pkg::OP_PROG_SUSPEND, esc_pkg::MODE_ERASE_SUSP, 0, 0, 0, 1},
      '{esc_pkg::OP_PROG_RESUME, esc_pkg::MODE_ERASE_SUSP, 0, 0, 0, 1},
      '{esc_pkg::OP_WORD_PROG, esc_pkg::MODE_PROG_BUSY, 0, 0, 0, 0},
      '{esc_pkg::OP_STAT_READ, esc_pkg::MODE_PROG_BUSY, 0, 0, 0, 0},
      '{esc_pkg::OP_RESET, esc_pkg::MODE_PROG_BUSY, 0, 0, 0, 1},
      '{esc_pkg::OP_PROG_SUSPEND, esc_pkg::MODE_PROG_SUSP, 0, 0, 0, 0},
      '{esc_pkg::OP_STAT_READ, esc_pkg::MODE_PROG_SUSP, 0, 0, 0, 0},
      '{esc_pkg::OP_RESET, esc_pkg::MODE_PROG_SUSP, 0, 0, 0, 0},
      '{esc_pkg::OP_PROG_RESUME, esc_pkg::MODE_PROG_BUSY, 1, 0, 0, 0},
      '{esc_pkg::OP_PROG_SUSPEND, esc_pkg::MODE_PROG_SUSP, 1, 0, 0, 0},
      '{esc_pkg::OP_PROG_RESUME, esc_pkg::MODE_PROG_BUSY, 0, 0, 0, 0},
      '{esc_pkg::OP_STAT_READ, esc_pkg::MODE_ERASE_SUSP, 0, 0, 400, 0},
      '{esc_pkg::OP_BUF_PROG, esc_pkg::MODE_PROG_BUSY, 0, 127, 0, 0},
      '{esc_pkg::OP_STAT_READ, esc_pkg::MODE_ERASE_SUSP, 0, 0, 400, 0},
      '{esc_pkg::OP_RESUME_ERASE, esc_pkg::MODE_ERASING, 0, 0, 0, 0},
      '{esc_pkg::OP_STAT_READ, esc_pkg::MODE_ERASING, 0, 0, 0, 0}};
    {rst_in, data_valid_in, cmd_valid_in, hang} = 4'hC;
    cmd_in = '0;
    data_in = 16'h1234;
    repeat (20) @(posedge clock_in);
    @(negedge clock_in);
    rst_in = 1'b0;
    chk({7'h0, cmd_ready_out, data_ready_out, pins_out.ce_n, pins_out.we_n, pins_out.oe_n,
      pins_out.dq_oe, mode_out}, 16'h0170);
    foreach (rows[i]) send(rows[i]);
    chk({12'h0, st}, 16'h0009);
    chk(status_out, 16'h0080);
    chk({15'h0, err}, 16'h0000);
    // Timed-out program: hang seen by status read, then reset command
    {rst_in, hang} = 2'b11;
    repeat (20) @(negedge clock_in);
    rst_in = 1'b0;
    send(rows[5]);
    send('{esc_pkg::OP_STAT_READ, esc_pkg::MODE_HANG, 0, 0, 400, 0});
    send('{esc_pkg::OP_RESET, esc_pkg::MODE_ERASE_SUSP, 0, 0, 0, 0});
    chk({12'h0, st}, 16'h0000);
    chk(status_out, 16'h00A0);
    give_verdict();
  end
endmodule : tb_erase_suspend_command_fsm
